// >>> rtl/fap_consts.svh
// offsets, field positions and reset values of the flash access protection block
`ifndef FAP_CONSTS_SVH
`define FAP_CONSTS_SVH

`define FAP_OFF_CTRL      8'h00
`define FAP_OFF_STATUS    8'h04
`define FAP_OFF_WP_B0A0   8'h10
`define FAP_OFF_WP_B0A1   8'h14
`define FAP_OFF_WP_B1A0   8'h18
`define FAP_OFF_WP_B1A1   8'h1c
`define FAP_OFF_EXEC_B0   8'h20
`define FAP_OFF_EXEC_B1   8'h24

`define FAP_CTRL_LVL_LSB  0
`define FAP_CTRL_KEEP_BIT 8
`define FAP_ST_LVL_LSB    0
`define FAP_ST_WIPE_BIT   4
`define FAP_ST_LOCK_BIT   5
`define FAP_ST_DENY_BIT   8
`define FAP_ST_CFGREF_BIT 9
`define FAP_ST_CAUSE_LSB  12
`define FAP_WP_FIRST_LSB  0
`define FAP_WP_LAST_LSB   16
`define FAP_EX_FIRST_LSB  0
`define FAP_EX_LAST_LSB   16

`define FAP_LVL_RST       2'h0
`define FAP_KEEP_RST      1'b0
`define FAP_WP_RST        32'h0000_00ff
`define FAP_EX_RST        32'h0000_ffff

`endif

// >>> rtl/fap_pkg.sv
// types of the flash access protection block
package fap_pkg;
  typedef enum logic [1:0] {
    FAP_M_CPU_I = 2'b00,
    FAP_M_CPU_D = 2'b01,
    FAP_M_DMA   = 2'b10,
    FAP_M_DBG   = 2'b11
  } fap_master_e;

  typedef enum logic [1:0] {
    FAP_OP_READ  = 2'b00,
    FAP_OP_PROG  = 2'b01,
    FAP_OP_ERASE = 2'b10,
    FAP_OP_NONE  = 2'b11
  } fap_op_e;

  typedef enum logic [1:0] {
    FAP_RG_MAIN   = 2'b00,
    FAP_RG_SYSMEM = 2'b01,
    FAP_RG_OPTION = 2'b10,
    FAP_RG_NONE   = 2'b11
  } fap_region_e;

  typedef enum logic [3:0] {
    FAP_C_NONE     = 4'h0,
    FAP_C_READOUT  = 4'h1,
    FAP_C_WPROT    = 4'h2,
    FAP_C_EXECONLY = 4'h3,
    FAP_C_SYSMEM   = 4'h4,
    FAP_C_OPTION   = 4'h5,
    FAP_C_ILLEGAL  = 4'h6
  } fap_cause_e;

  typedef enum logic [2:0] {
    FAP_W_IDLE = 3'b000,
    FAP_W_BKP  = 3'b001,
    FAP_W_SRAM = 3'b010,
    FAP_W_PAGE = 3'b011,
    FAP_W_GAP  = 3'b100,
    FAP_W_WAIT = 3'b101,
    FAP_W_DONE = 3'b110
  } fap_wipe_e;
endpackage

// >>> rtl/fap_range_hit.sv
// inclusive range overlap test of one protected area against a query span
`timescale 1ns/1ps
`default_nettype none
module fap_range_hit #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] first,
  input  wire logic [W-1:0] last,
  input  wire logic [W-1:0] q_lo,
  input  wire logic [W-1:0] q_hi,
  output logic              hit
);
  // first above last marks the area as unused
  assign hit = (first <= last) && (first <= q_hi) && (last >= q_lo);
endmodule
`default_nettype wire

// >>> rtl/fap_core.sv
// flash access protection: readout level, write protect and execute-only checks
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fap_consts.svh"

// Notes on behaviour
// R1 - read other bank while one bank busy
// R2 - bank is 256 pages of 2 Kbyte
// R3 - level 0 allows everything everywhere; the code still refuses per R6, R8 and R9 at level 0
// R4 - level 1 blocks main flash when untrusted
// R5 - level 2 locks debug, boot, level
// R6 - sysmem read-only; options locked at level 2
// R7 - level 1 to 0 wipes before access
// R8 - two write-protect page areas per bank
// R9 - execute-only area: CPU fetch only
// R10 - one execute-only area per bank, 64-bit
// R11 - option bit keeps execute-only area on wipe
// R12 - refused access leaves flash untouched, flagged
module fap_core
  import fap_pkg::*;
#(
  parameter int PAGE_W = 8,
  parameter int OFS_W  = 11
) (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  // register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  // execution context
  input  wire logic                    dbg_attached,
  input  wire logic                    boot_ram,
  input  wire logic                    boot_loader,
  output logic                         dbg_port_en,
  output logic                         boot_ram_en,
  output logic                         boot_loader_en,
  // access request from the bus masters
  input  wire logic                    req_valid,
  input  wire logic [1:0]              req_master,
  input  wire logic [1:0]              req_op,
  input  wire logic [1:0]              req_region,
  input  wire logic [PAGE_W+OFS_W:0]   req_addr,
  output logic                         req_ready,
  output logic                         rsp_ok,
  output logic                         rsp_err,
  // flash bank side
  input  wire logic [1:0]              bank_busy,
  output logic                         fl_rd,
  output logic                         fl_prog,
  output logic                         fl_erase,
  output logic      [1:0]              fl_region,
  output logic      [PAGE_W+OFS_W:0]   fl_addr,
  // wipe of retained content on downgrade
  output logic                         bkp_wipe,
  output logic                         sram_wipe
);
  localparam int DW_W = PAGE_W + OFS_W - 3;
  localparam int AW   = PAGE_W + OFS_W + 1;
  if (PAGE_W != 8 || OFS_W != 11) begin : g_bad_geom
    $error("fap_core: only 8 page bits and 11 offset bits are served");
  end
  // ==========================================================
  // configuration registers
  logic [1:0]      level_r;
  logic            keep_exec_r;
  logic [31:0]     wp_r [4];
  logic [31:0]     ex_r [2];
  logic            deny_flag_r;
  logic            cfg_ref_r;
  fap_cause_e      cause_r;
  fap_wipe_e       wipe_r;
  logic [PAGE_W:0] wpg_r;
  logic            wiping;
  logic            locked;
  logic            cfg_wr;
  logic [1:0]      lvl_req;
  logic            lvl_refuse;
  logic            wipe_start;
  logic            wipe_last;
  assign wiping  = (wipe_r != FAP_W_IDLE);
  assign locked  = (level_r == 2'h2);
  assign lvl_req = reg_wdata[`FAP_CTRL_LVL_LSB +: 2];
  assign cfg_wr  = reg_wr && (reg_addr != `FAP_OFF_STATUS) && (reg_addr != `FAP_OFF_CTRL);
  // options are read-only once locked, level is frozen while wiping
  assign lvl_refuse = reg_wr && (reg_addr == `FAP_OFF_CTRL) &&
                      (locked || wiping || lvl_req == 2'h3); // R5
  assign wipe_start = reg_wr && (reg_addr == `FAP_OFF_CTRL) && !lvl_refuse &&
                      (level_r == 2'h1) && (lvl_req == 2'h0); // R7
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      level_r     <= `FAP_LVL_RST;
      keep_exec_r <= `FAP_KEEP_RST;
    end else if (wipe_r == FAP_W_DONE) begin
      level_r <= 2'h0; // R7
    end else if (reg_wr && reg_addr == `FAP_OFF_CTRL && !lvl_refuse) begin
      keep_exec_r <= reg_wdata[`FAP_CTRL_KEEP_BIT]; // R11
      if (!wipe_start) begin
        level_r <= lvl_req;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        wp_r[i] <= `FAP_WP_RST;
      end
      ex_r[0] <= `FAP_EX_RST;
      ex_r[1] <= `FAP_EX_RST;
    end else if (cfg_wr && !locked && !wiping) begin // R6
      unique case (reg_addr)
        `FAP_OFF_WP_B0A0: wp_r[0] <= reg_wdata;
        `FAP_OFF_WP_B0A1: wp_r[1] <= reg_wdata;
        `FAP_OFF_WP_B1A0: wp_r[2] <= reg_wdata;
        `FAP_OFF_WP_B1A1: wp_r[3] <= reg_wdata;
        `FAP_OFF_EXEC_B0: ex_r[0] <= reg_wdata;
        `FAP_OFF_EXEC_B1: ex_r[1] <= reg_wdata;
        default: ;
      endcase
    end
  end
  // ==========================================================
  // area decode
  logic              q_bank;
  logic [PAGE_W-1:0] q_page;
  logic [DW_W-1:0]   q_dw_lo;
  logic [DW_W-1:0]   q_dw_hi;
  logic [3:0]        wp_hit;
  logic [1:0]        ex_hit;
  logic              in_wp;
  logic              in_ex;
  // during a wipe the page walker owns the decoders; requests are stalled then
  assign q_bank = wiping ? wpg_r[PAGE_W] : req_addr[AW-1];
  assign q_page = wiping ? wpg_r[PAGE_W-1:0] : req_addr[OFS_W +: PAGE_W]; // R2
  assign q_dw_lo = (wiping || fap_op_e'(req_op) == FAP_OP_ERASE) ?
                   {q_page, {(OFS_W-3){1'b0}}} : req_addr[3 +: DW_W];
  assign q_dw_hi = (wiping || fap_op_e'(req_op) == FAP_OP_ERASE) ?
                   {q_page, {(OFS_W-3){1'b1}}} : req_addr[3 +: DW_W];
  for (genvar g = 0; g < 4; g++) begin : g_wp
    fap_range_hit #(.W(PAGE_W)) u_wp (
      .first (wp_r[g][`FAP_WP_FIRST_LSB +: PAGE_W]),
      .last  (wp_r[g][`FAP_WP_LAST_LSB +: PAGE_W]),
      .q_lo  (q_page),
      .q_hi  (q_page),
      .hit   (wp_hit[g])
    ); // R8
  end
  for (genvar g = 0; g < 2; g++) begin : g_ex
    fap_range_hit #(.W(DW_W)) u_ex (
      .first (ex_r[g][`FAP_EX_FIRST_LSB +: DW_W]),
      .last  (ex_r[g][`FAP_EX_LAST_LSB +: DW_W]),
      .q_lo  (q_dw_lo),
      .q_hi  (q_dw_hi),
      .hit   (ex_hit[g])
    ); // R10
  end
  assign in_wp = q_bank ? (wp_hit[2] | wp_hit[3]) : (wp_hit[0] | wp_hit[1]);
  assign in_ex = q_bank ? ex_hit[1] : ex_hit[0];
  // ==========================================================
  // access decision
  logic       untrusted;
  logic       is_write;
  logic       deny;
  fap_cause_e cause;
  assign untrusted = dbg_attached || boot_ram || boot_loader ||
                     fap_master_e'(req_master) == FAP_M_DBG;
  assign is_write  = fap_op_e'(req_op) != FAP_OP_READ;
  always_comb begin
    cause = FAP_C_NONE; // R3
    if (fap_op_e'(req_op) == FAP_OP_NONE || fap_region_e'(req_region) == FAP_RG_NONE) begin
      cause = FAP_C_ILLEGAL;
    end else if (locked && untrusted) begin
      cause = FAP_C_READOUT; // R5
    end else begin
      unique case (fap_region_e'(req_region))
        FAP_RG_MAIN: begin
          if (level_r != 2'h0 && untrusted) begin
            cause = FAP_C_READOUT; // R4
          end else if (in_ex && !(fap_master_e'(req_master) == FAP_M_CPU_I && !is_write)) begin
            cause = FAP_C_EXECONLY; // R9
          end else if (is_write && in_wp) begin
            cause = FAP_C_WPROT; // R8
          end
        end
        FAP_RG_SYSMEM: begin
          if (is_write) begin
            cause = FAP_C_SYSMEM; // R6
          end
        end
        FAP_RG_OPTION: begin
          if (locked && is_write) begin
            cause = FAP_C_OPTION; // R6
          end
        end
        default: cause = FAP_C_ILLEGAL;
      endcase
    end
  end
  assign deny = (cause != FAP_C_NONE);
  // only the addressed bank stalls; the other bank keeps serving reads
  assign req_ready = !wiping &&
                     !(fap_region_e'(req_region) == FAP_RG_MAIN && bank_busy[req_addr[AW-1]]); // R1
  logic take;
  assign take = req_valid && req_ready;
  // ==========================================================
  // answer and flash command, one cycle after the request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_ok  <= 1'b0;
      rsp_err <= 1'b0;
    end else begin
      rsp_ok  <= take && !deny;
      rsp_err <= take && deny; // R12
    end
  end
  logic wipe_issue;
  assign wipe_issue = (wipe_r == FAP_W_PAGE) && !bank_busy[wpg_r[PAGE_W]] &&
                      !(keep_exec_r && in_ex); // R11
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fl_rd     <= 1'b0;
      fl_prog   <= 1'b0;
      fl_erase  <= 1'b0;
      fl_region <= 2'h0;
      fl_addr   <= '0;
    end else if (wipe_issue) begin
      fl_rd     <= 1'b0;
      fl_prog   <= 1'b0;
      fl_erase  <= 1'b1; // R7
      fl_region <= FAP_RG_MAIN;
      fl_addr   <= {wpg_r, {OFS_W{1'b0}}};
    end else begin
      // a refused access never reaches the banks
      fl_rd    <= take && !deny && fap_op_e'(req_op) == FAP_OP_READ; // R12
      fl_prog  <= take && !deny && fap_op_e'(req_op) == FAP_OP_PROG;
      fl_erase <= take && !deny && fap_op_e'(req_op) == FAP_OP_ERASE;
      if (take) begin
        fl_region <= req_region;
        fl_addr   <= req_addr;
      end
    end
  end
  // ==========================================================
  // wipe sequence on downgrade
  assign wipe_last = (wpg_r == {(PAGE_W+1){1'b1}});
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wipe_r <= FAP_W_IDLE;
      wpg_r  <= '0;
    end else begin
      unique case (wipe_r)
        FAP_W_IDLE: begin
          wpg_r <= '0;
          if (wipe_start) begin
            wipe_r <= FAP_W_BKP; // R7
          end
        end
        FAP_W_BKP:  wipe_r <= FAP_W_SRAM;
        FAP_W_SRAM: wipe_r <= FAP_W_PAGE;
        FAP_W_PAGE: begin
          if (wipe_issue) begin
            wipe_r <= FAP_W_GAP;
          end else if (keep_exec_r && in_ex) begin
            // a page touching the kept area is skipped whole
            wipe_r <= wipe_last ? FAP_W_DONE : FAP_W_PAGE;
            wpg_r  <= wpg_r + 1'b1;
          end
        end
        // busy rises one cycle after the erase command
        FAP_W_GAP:  wipe_r <= FAP_W_WAIT;
        FAP_W_WAIT: begin
          if (!bank_busy[wpg_r[PAGE_W]]) begin
            wipe_r <= wipe_last ? FAP_W_DONE : FAP_W_PAGE;
            wpg_r  <= wpg_r + 1'b1;
          end
        end
        FAP_W_DONE: wipe_r <= FAP_W_IDLE;
        default:    wipe_r <= FAP_W_IDLE;
      endcase
    end
  end
  assign bkp_wipe  = (wipe_r == FAP_W_BKP);
  assign sram_wipe = (wipe_r == FAP_W_SRAM);
  // level 2 is a fuse: these stay off until power-on with a new level
  assign dbg_port_en    = !locked; // R5
  assign boot_ram_en    = !locked;
  assign boot_loader_en = !locked;
  // ==========================================================
  // status flags: a new event wins over a write-one clear
  logic st_clr;
  assign st_clr = reg_wr && reg_addr == `FAP_OFF_STATUS;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      deny_flag_r <= 1'b0;
      cause_r     <= FAP_C_NONE;
    end else if (take && deny) begin
      deny_flag_r <= 1'b1; // R12
      cause_r     <= cause;
    end else if (st_clr && reg_wdata[`FAP_ST_DENY_BIT]) begin
      deny_flag_r <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ref_r <= 1'b0;
    end else if (lvl_refuse || (cfg_wr && (locked || wiping))) begin
      cfg_ref_r <= 1'b1; // R5
    end else if (st_clr && reg_wdata[`FAP_ST_CFGREF_BIT]) begin
      cfg_ref_r <= 1'b0;
    end
  end
  // ==========================================================
  // register read
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `FAP_OFF_CTRL:    reg_rdata <= 32'(level_r) | (32'(keep_exec_r) << `FAP_CTRL_KEEP_BIT);
        `FAP_OFF_STATUS:  reg_rdata <= (32'(level_r) << `FAP_ST_LVL_LSB) |
                                       (32'(wiping) << `FAP_ST_WIPE_BIT) |
                                       (32'(locked) << `FAP_ST_LOCK_BIT) |
                                       (32'(deny_flag_r) << `FAP_ST_DENY_BIT) |
                                       (32'(cfg_ref_r) << `FAP_ST_CFGREF_BIT) |
                                       (32'(cause_r) << `FAP_ST_CAUSE_LSB);
        `FAP_OFF_WP_B0A0: reg_rdata <= wp_r[0];
        `FAP_OFF_WP_B0A1: reg_rdata <= wp_r[1];
        `FAP_OFF_WP_B1A0: reg_rdata <= wp_r[2];
        `FAP_OFF_WP_B1A1: reg_rdata <= wp_r[3];
        `FAP_OFF_EXEC_B0: reg_rdata <= ex_r[0];
        `FAP_OFF_EXEC_B1: reg_rdata <= ex_r[1];
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/fap_core_checker.sv
// port assertions of the flash access protection core
`timescale 1ns/1ps
`default_nettype none
module fap_core_checker #(
  parameter int PAGE_W = 8,
  parameter int OFS_W  = 11
) (
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire logic                  req_valid,
  input wire logic [1:0]            req_master,
  input wire logic [1:0]            req_op,
  input wire logic [1:0]            req_region,
  input wire logic [PAGE_W+OFS_W:0] req_addr,
  input wire logic                  req_ready,
  input wire logic                  rsp_ok,
  input wire logic                  rsp_err,
  input wire logic [1:0]            bank_busy,
  input wire logic                  fl_rd,
  input wire logic                  fl_prog,
  input wire logic                  fl_erase,
  input wire logic [PAGE_W+OFS_W:0] fl_addr,
  input wire logic                  dbg_port_en,
  input wire logic                  boot_ram_en,
  input wire logic                  boot_loader_en,
  input wire logic                  bkp_wipe,
  input wire logic                  sram_wipe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic acc;
  assign acc = req_valid && req_ready;
  // ==========================================
  // answers and grants
  a_one_answer: assert property (acc |=> rsp_ok != rsp_err)
    else $error("accepted request without a single answer");
  a_no_stray: assert property (!acc |=> !(rsp_ok || rsp_err))
    else $error("answer without an accepted request");
  a_grant_only: assert property ((fl_rd || fl_prog) |-> rsp_ok && !rsp_err)
    else $error("flash access without a grant");
  a_read_addr: assert property (fl_rd |-> fl_addr == $past(req_addr))
    else $error("flash read address differs from request");
  a_sysmem_ro: assert property (acc && req_region == 2'h1 && req_op inside {2'h1, 2'h2}
    |=> rsp_err && !fl_prog && !fl_erase) else $error("system memory write granted");
  a_busy_stall: assert property (req_valid && req_region == 2'h0
    && bank_busy[req_addr[PAGE_W+OFS_W]] |-> !req_ready) else $error("busy bank accepted");
  // ==========================================
  // locking and wipe
  a_ctx_locks: assert property (dbg_port_en == boot_ram_en && boot_ram_en == boot_loader_en)
    else $error("context enables disagree");
  a_lock_sticky: assert property (!dbg_port_en |=> !dbg_port_en)
    else $error("debug port unlocked again");
  a_lvl2_dbg: assert property (!dbg_port_en && acc && req_master == 2'h3 |=> rsp_err)
    else $error("debug master served while locked");
  a_wipe_order: assert property (bkp_wipe |=> sram_wipe && !bkp_wipe)
    else $error("retained memory wipe out of order");
  a_wipe_page: assert property (fl_erase && !rsp_ok |-> fl_addr[OFS_W-1:0] == '0)
    else $error("wipe erase not on a page base");
endmodule
`default_nettype wire

// >>> tb/fap_flash_model.sv
// flash bank model: each bank busy for a while after program or erase
`timescale 1ns/1ps
`default_nettype none
module fap_flash_model #(
  parameter int BUSY = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        fl_prog,
  input  wire logic        fl_erase,
  input  wire logic [19:0] fl_addr,
  output logic      [1:0]  bank_busy
);
  int cnt [2];
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '{0, 0};
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((fl_prog || fl_erase) && fl_addr[19] == b[0]) begin
          cnt[b] <= BUSY;
        end else if (cnt[b] > 0) begin
          cnt[b] <= cnt[b] - 1;
        end
      end
    end
  end
  // banks count apart so one can be read while the other works
  assign bank_busy = {cnt[1] > 0, cnt[0] > 0};
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench of the flash access protection core
`timescale 1ns/1ps
`default_nettype none
`include "fap_consts.svh"
module tb_top;
  logic        sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v, seed = 32'h55;
  logic        dbg_attached = 1'b0, boot_ram = 1'b0, boot_loader = 1'b0;
  logic        dbg_port_en, boot_ram_en, boot_loader_en, bkp_wipe, sram_wipe;
  logic        req_valid = 1'b0, req_ready, rsp_ok, rsp_err, fl_rd, fl_prog, fl_erase;
  logic [1:0]  req_master = 2'h0, req_op = 2'h0, req_region = 2'h0, bank_busy, fl_region;
  logic [19:0] req_addr = 20'h0, fl_addr;
  int          fail_count = 0, cmp_count = 0, ecount = 0, wcount = 0, lvl = 0, w;
  logic [7:0]  ra [4] = '{`FAP_OFF_CTRL, `FAP_OFF_WP_B0A0, `FAP_OFF_EXEC_B1, 8'h40};
  logic [31:0] rv [4] = '{32'h0, `FAP_WP_RST, `FAP_EX_RST, 32'h0};
  // {master, op, region, addr}: area edges, system memory, option bytes, illegal op
  logic [25:0] dm [12] = '{26'h1402000, 26'h1403000, 26'h1403800, 26'h1801800, 26'h0080100,
    26'h2080100, 26'h1080080, 26'h2080108, 26'h1880000, 26'h1500000, 26'h1a00000, 26'h1c00000};

  fap_core fap_core_inst (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .dbg_attached, .boot_ram, .boot_loader, .dbg_port_en, .boot_ram_en,
    .boot_loader_en, .req_valid, .req_master, .req_op, .req_region, .req_addr, .req_ready,
    .rsp_ok, .rsp_err, .bank_busy, .fl_rd, .fl_prog, .fl_erase, .fl_region, .fl_addr,
    .bkp_wipe, .sram_wipe);
  fap_flash_model fap_flash_model_inst (.sys_clk, .resetn, .fl_prog, .fl_erase, .fl_addr,
    .bank_busy);

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    ecount += fl_erase;
    wcount += int'(bkp_wipe) + int'(sram_wipe);
  end

  // ==========================================
  // reference model and helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic bit exp_ok(logic [1:0] m, op, rg, logic [19:0] a, logic [2:0] c);
    bit untr, exh;
    untr = (c != 3'h0) || (m == 2'h3);
    exh = a[19] && (op == 2'h2 ? a[18:11] == 8'h0 : a[18:3] inside {[16'h10:16'h20]});
    if (op == 2'h3 || rg == 2'h3) return 0;
    if (lvl == 2 && untr) return 0;
    if (rg == 2'h0 && lvl != 0 && untr) return 0;
    if (rg == 2'h0 && exh && !(m == 2'h0 && op == 2'h0)) return 0;
    if (rg == 2'h0 && !a[19] && a[18:11] inside {[8'h4:8'h6]} && op != 2'h0) return 0;
    if (rg == 2'h1 && op != 2'h0) return 0;
    if (rg == 2'h2 && op != 2'h0 && lvl == 2) return 0;
    return 1;
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  // ready is looked at mid-cycle, where it has settled
  task automatic req(input logic [1:0] m, op, rg, input logic [19:0] a, input logic [2:0] c,
                     output int wt);
    logic e;
    e = exp_ok(m, op, rg, a, c);
    @(posedge sys_clk);
    {req_master, req_op, req_region, req_addr} <= {m, op, rg, a};
    {dbg_attached, boot_ram, boot_loader} <= c;
    req_valid <= 1'b1;
    wt = 0;
    @(negedge sys_clk);
    while (!req_ready && wt < 100) begin
      wt++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    @(negedge sys_clk);
    chk({rsp_ok, rsp_err, fl_rd, fl_prog, fl_erase, fl_region, fl_addr},
        {e, !e, e && op == 2'h0, e && op == 2'h1, e && op == 2'h2, rg, a});
  endtask
  task automatic rand_run(input int n);
    logic [31:0] r;
    logic [2:0]  c;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      c = (r[31:30] == 2'h0) ? 3'h0 : r[26:24];
      req(r[13:12], 2'(r[21:14] % 3), 2'(r[29:22] % 3), {r[0], 5'h0, r[3:1], r[11:4], 3'h0}, c, w);
    end
  endtask
  task automatic dir_run();
    foreach (dm[i]) begin
      req(dm[i][25:24], dm[i][23:22], dm[i][21:20], dm[i][19:0], 3'h0, w);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk(v, rv[i]);
    end
    wr(`FAP_OFF_WP_B0A0, 32'h0006_0004);
    wr(`FAP_OFF_EXEC_B1, 32'h0020_0010);
    req(2'h1, 2'h1, 2'h0, 20'h00000, 3'h0, w);
    req(2'h1, 2'h0, 2'h0, 20'h80800, 3'h0, w);
    chk(w, 0);
    req(2'h1, 2'h0, 2'h0, 20'h00800, 3'h0, w);
    chk(32'(w != 0), 32'h1);
    dir_run();
    rand_run(60);
    // first wipe keeps the execute-only page, the second erases it too
    for (int k = 1; k >= 0; k--) begin
      wr(`FAP_OFF_CTRL, 32'h1);
      lvl = 1;
      rand_run(60);
      wr(`FAP_OFF_CTRL, 32'(k) << `FAP_CTRL_KEEP_BIT);
      // counted from here so a late erase grant of the random run is left out
      ecount = 0;
      wcount = 0;
      for (int i = 0; i < 4000; i++) begin
        rd(`FAP_OFF_STATUS, v);
        if (v[1:0] == 2'h0) break;
      end
      lvl = 0;
      chk(ecount, 512 - k);
      chk(wcount, 2);
    end
    wr(`FAP_OFF_CTRL, 32'h2);
    lvl = 2;
    @(negedge sys_clk);
    chk({dbg_port_en, boot_ram_en, boot_loader_en}, 0);
    wr(`FAP_OFF_CTRL, 32'h0);
    rd(`FAP_OFF_STATUS, v);
    chk(v & 32'h233, 32'h222);
    dir_run();
    rand_run(40);
    results();
  end

  // a hang ends the run long after the sequence should have finished
  initial begin
    #300_000;
    fail_count++;
    results();
  end
endmodule

bind fap_core fap_core_checker #(.PAGE_W(PAGE_W), .OFS_W(OFS_W)) fap_core_checker_inst (
  .sys_clk, .resetn, .req_valid, .req_master, .req_op, .req_region, .req_addr, .req_ready,
  .rsp_ok, .rsp_err, .bank_busy, .fl_rd, .fl_prog, .fl_erase, .fl_addr, .dbg_port_en,
  .boot_ram_en, .boot_loader_en, .bkp_wipe, .sram_wipe);
`default_nettype wire
